// ### rtl/dru_top.sv
`timescale 1ns/10ps
module dru_top
  import dru_pkg::*;
#(
  parameter logic [6:0] CHANNEL_KIND = KIND_ANA_IN
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        diag_irq_en_i,
  input  wire logic        aux_missing_i,
  input  wire logic        buf_overflow_i,
  input  wire logic        comm_error_i,
  input  wire logic        config_error_i,
  input  wire logic        range_under_i,
  input  wire logic        range_over_i,
  input  wire logic        exc_short_i,
  input  wire logic        module_failure_i,
  input  wire logic        external_error_i,
  input  wire logic        rd_req_i,
  input  dru_acc_t         acc_mode_i,
  input  wire logic [15:0] sel_i,
  input  wire logic [7:0]  sub_i,
  input  wire logic [4:0]  ofs_i,
  output logic             irq_coming_o,
  output logic             irq_going_o,
  output logic             irq_active_o,
  output logic             record_valid_o,
  output logic             module_fault_lamp_o,
  output logic [31:0]      tick_o,
  output logic             rd_ack_o,
  output logic             rd_err_o,
  output logic [7:0]       rd_data_o
);
  dru_fault_if fault_bus ();

  logic [5:0]  sync1_reg;
  logic [5:0]  sync2_reg;
  logic [2:0]  sync1b_reg;
  logic [2:0]  sync2b_reg;
  logic        cause_any;
  logic        coming_p;
  logic        going_p;
  dru_state_t  state_reg;
  dru_state_t  state_next;
  logic [7:0]  summary_reg;
  logic [7:0]  internal_reg;
  logic [7:0]  map_reg;
  logic [7:0]  detail0_reg;
  logic [31:0] stamp_reg;
  logic        valid_reg;
  logic [7:0]  class_byte;
  logic [7:0]  kind_byte;
  logic [REC_LEN*8-1:0] record;

  // two-flop synchronisers for the external cause levels
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync1_reg  <= 6'h00;
      sync2_reg  <= 6'h00;
      sync1b_reg <= 3'h0;
      sync2b_reg <= 3'h0;
    end else begin
      sync1_reg  <= {range_over_i, range_under_i, config_error_i,
                     comm_error_i, buf_overflow_i, aux_missing_i};
      sync2_reg  <= sync1_reg;
      sync1b_reg <= {exc_short_i, module_failure_i, external_error_i};
      sync2b_reg <= sync1b_reg;
    end
  end

  // any of the six causes
  assign cause_any = |sync2_reg;

  // interrupt state: idle, alarm active, going announced
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cause_any && diag_irq_en_i) state_next = ST_ALARM;
      end
      ST_ALARM: begin
        if (!cause_any) state_next = ST_CLEAR;
      end
      ST_CLEAR: begin
        state_next = (cause_any && diag_irq_en_i) ? ST_ALARM : ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // event pulses derived from transitions
  assign coming_p = (state_reg != ST_ALARM) && (state_next == ST_ALARM);
  assign going_p  = (state_reg == ST_ALARM) && (state_next == ST_CLEAR);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) state_reg <= ST_IDLE;
    else        state_reg <= state_next;
  end

  // interrupt pulses and lamp
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_coming_o        <= 1'b0;
      irq_going_o         <= 1'b0;
      module_fault_lamp_o <= 1'b0;
    end else begin
      irq_coming_o        <= coming_p;
      irq_going_o         <= going_p;
      module_fault_lamp_o <= (state_next == ST_ALARM);
    end
  end
  assign irq_active_o = module_fault_lamp_o;

  // timestamp capture at each incoming interrupt
  dru_ticker u_ticker (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .capture_i  (coming_p),
    .tick_o     (tick_o),
    .fault_src  (fault_bus)
  );

  // fault bytes follow the synchronised causes every cycle; stamp held from the event
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      summary_reg  <= RST_BYTE;
      internal_reg <= RST_BYTE;
      map_reg      <= RST_BYTE;
      detail0_reg  <= RST_BYTE;
      stamp_reg    <= RST_TICK;
      valid_reg    <= 1'b0;
    end else begin
      if (fault_bus.event_p) begin
        stamp_reg <= fault_bus.stamp;
        valid_reg <= 1'b1;
      end
      summary_reg  <= RST_BYTE;
      summary_reg[SUM_MOD_FAIL] <= sync2b_reg[1];
      summary_reg[SUM_EXT_ERR]  <= sync2b_reg[0];
      summary_reg[SUM_CH_ERR]   <= |map_next();
      summary_reg[SUM_AUX_MISS] <= sync2_reg[0];
      summary_reg[SUM_CFG_ERR]  <= sync2_reg[3];
      internal_reg <= RST_BYTE;
      internal_reg[INT_BUF_OVF]  <= sync2_reg[1];
      internal_reg[INT_COMM_ERR] <= sync2_reg[2];
      map_reg     <= map_next();
      detail0_reg <= detail_next();
    end
  end

  // channel 0 detail bits from the synchronised causes
  function automatic logic [7:0] detail_next();
    logic [7:0] d;
    d = RST_BYTE;
    d[DET_CFG_ERR]   = sync2_reg[3];
    d[DET_EXC_SHORT] = sync2b_reg[2];
    d[DET_UNDER]     = sync2_reg[4];
    d[DET_OVER]      = sync2_reg[5];
    return d;
  endfunction : detail_next

  // channel map: bit 0 set while channel 0 reports any error
  function automatic logic [7:0] map_next();
    logic [7:0] m;
    m = RST_BYTE;
    m[0] = |detail_next();
    return m;
  endfunction : map_next

  // fixed descriptor bytes
  assign class_byte = {3'b000, 1'b1, CLASS_ANALOG};
  assign kind_byte  = {1'b0, CHANNEL_KIND};

  // record image, byte 0 in the low bits
  assign record = {stamp_reg,
                   56'h0000_0000_0000_00, detail0_reg,
                   map_reg, CHANNEL_COUNT_VAL, DIAG_BITS_PER_CHANNEL_VAL,
                   kind_byte, internal_reg, RST_BYTE,
                   class_byte, summary_reg};

  assign record_valid_o = valid_reg;

  // record reader for all three access paths
  dru_reader u_reader (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .rd_req_i   (rd_req_i),
    .acc_mode_i (acc_mode_i),
    .sel_i      (sel_i),
    .sub_i      (sub_i),
    .ofs_i      (ofs_i),
    .record_i   (record),
    .rd_ack_o   (rd_ack_o),
    .rd_err_o   (rd_err_o),
    .rd_data_o  (rd_data_o)
  );
endmodule : dru_top

// ### rtl/dru_pkg.sv
package dru_pkg;
  // record access selectors
  localparam logic [7:0]  REC_NUM_HEAD   = 8'h00;
  localparam logic [7:0]  REC_NUM_FULL   = 8'h01;
  localparam logic [15:0] OBJ_IDX_HEAD   = 16'h2F00;
  localparam logic [15:0] OBJ_IDX_FULL   = 16'h2F01;
  localparam logic [15:0] ETH_IDX        = 16'h5005;
  localparam logic [7:0]  ETH_SUB_FIRST  = 8'h02;
  localparam logic [7:0]  ETH_SUB_DETAIL = 8'h0A;
  localparam logic [7:0]  ETH_SUB_DLAST  = 8'h11;
  localparam logic [7:0]  ETH_SUB_TSTAMP = 8'h13;
  // record layout
  localparam int          REC_LEN        = 20;
  localparam int          REC_HEAD_LEN   = 4;
  localparam int          OFS_SUMMARY    = 0;
  localparam int          OFS_CLASS      = 1;
  localparam int          OFS_SPARE      = 2;
  localparam int          OFS_INTERNAL   = 3;
  localparam int          OFS_KIND       = 4;
  localparam int          OFS_DIAG_BITS_PER_CHANNEL     = 5;
  localparam int          OFS_CHANNEL_COUNT      = 6;
  localparam int          OFS_MAP        = 7;
  localparam int          OFS_DETAIL     = 8;
  localparam int          OFS_TSTAMP     = 16;
  // summary byte fields
  localparam int          SUM_MOD_FAIL   = 0;
  localparam int          SUM_EXT_ERR    = 2;
  localparam int          SUM_CH_ERR     = 3;
  localparam int          SUM_AUX_MISS   = 4;
  localparam int          SUM_CFG_ERR    = 7;
  // internal fault byte fields
  localparam int          INT_BUF_OVF    = 3;
  localparam int          INT_COMM_ERR   = 4;
  // channel detail byte 0 fields
  localparam int          DET_CFG_ERR    = 0;
  localparam int          DET_EXC_SHORT  = 3;
  localparam int          DET_UNDER      = 6;
  localparam int          DET_OVER       = 7;
  // fixed descriptor values
  localparam logic [3:0]  CLASS_ANALOG   = 4'h5;
  localparam int          CLASS_CHINFO   = 4;
  localparam logic [6:0]  KIND_DIG_IN    = 7'h70;
  localparam logic [6:0]  KIND_ANA_IN    = 7'h71;
  localparam logic [6:0]  KIND_DIG_OUT   = 7'h72;
  localparam logic [6:0]  KIND_ANA_OUT   = 7'h73;
  localparam logic [6:0]  KIND_ANA_IO    = 7'h74;
  localparam logic [6:0]  KIND_COUNTER   = 7'h76;
  localparam logic [7:0]  DIAG_BITS_PER_CHANNEL_VAL     = 8'h08;
  localparam logic [7:0]  CHANNEL_COUNT_VAL      = 8'h01;
  // reset values
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [31:0] RST_TICK       = 32'h0000_0000;
  // timing
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          TICK_NS        = 1000;
  localparam int          CLK_NS         = 1_000_000_000 / CLK_HZ;
  localparam int          TICK_CYCLES    = TICK_NS / CLK_NS;
  // access modes and interrupt states
  typedef enum logic [1:0] {
    ACC_RECORD = 2'b00,
    ACC_OBJECT = 2'b01,
    ACC_ETHSUB = 2'b10
  } dru_acc_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ALARM = 2'b01,
    ST_CLEAR = 2'b10
  } dru_state_t;
endpackage : dru_pkg

// ### rtl/dru_fault_if.sv
`timescale 1ns/10ps
// carries the event pulse and captured timestamp between the ticker and record logic
interface dru_fault_if;
  logic        event_p;
  logic [31:0] stamp;
  modport src (output event_p, output stamp);
  modport dst (input  event_p, input  stamp);
endinterface : dru_fault_if

// ### rtl/dru_ticker.sv
`timescale 1ns/10ps
// microsecond ticker with capture on a diagnostic event
module dru_ticker
  import dru_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic capture_i,
  output logic [31:0] tick_o,
  dru_fault_if.src  fault_src
);
  logic [$clog2(TICK_DIV+1)-1:0] div_reg;
  logic [31:0]                   stamp_reg;
  logic                          us_en;
  logic                          ev_reg;

  // one-cycle enable each microsecond
  assign us_en = (div_reg == ($clog2(TICK_DIV+1))'(TICK_DIV - 1));

  // divider and wrapping 32-bit counter from zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      div_reg <= '0;
      tick_o  <= RST_TICK;
    end else begin
      div_reg <= us_en ? '0 : div_reg + 1'b1;
      if (us_en) tick_o <= tick_o + 32'h0000_0001;
    end
  end

  // capture the ticker at the event
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stamp_reg <= RST_TICK;
      ev_reg    <= 1'b0;
    end else begin
      ev_reg <= capture_i;
      if (capture_i) stamp_reg <= tick_o;
    end
  end

  assign fault_src.event_p = ev_reg;
  assign fault_src.stamp   = stamp_reg;
endmodule : dru_ticker

// ### rtl/dru_reader.sv
`timescale 1ns/10ps
// selects one record byte from access mode, selector and byte offset
module dru_reader
  import dru_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       rd_req_i,
  input  dru_acc_t        acc_mode_i,
  input  wire logic [15:0] sel_i,
  input  wire logic [7:0]  sub_i,
  input  wire logic [4:0]  ofs_i,
  input  wire logic [REC_LEN*8-1:0] record_i,
  output logic            rd_ack_o,
  output logic            rd_err_o,
  output logic [7:0]      rd_data_o
);
  logic       hit;
  logic [4:0] pos;

  // map a subindex onto a record byte
  function automatic logic [4:0] sub_pos(input logic [7:0] s);
    if (s == ETH_SUB_TSTAMP)
      sub_pos = 5'(OFS_TSTAMP);
    else
      sub_pos = 5'(s - ETH_SUB_FIRST);
  endfunction : sub_pos

  // decode of the addressed byte and its legality
  assign pos = (acc_mode_i == ACC_ETHSUB) ? sub_pos(sub_i) : ofs_i;
  assign hit =
    (acc_mode_i == ACC_RECORD) ?
      ((sel_i[7:0] == REC_NUM_FULL && ofs_i < 5'(REC_LEN)) ||
       (sel_i[7:0] == REC_NUM_HEAD && ofs_i < 5'(REC_HEAD_LEN))) :
    (acc_mode_i == ACC_OBJECT) ?
      ((sel_i == OBJ_IDX_FULL && ofs_i < 5'(REC_LEN)) ||
       (sel_i == OBJ_IDX_HEAD && ofs_i < 5'(REC_HEAD_LEN))) :
    (acc_mode_i == ACC_ETHSUB) ?
      (sel_i == ETH_IDX &&
       ((sub_i >= ETH_SUB_FIRST && sub_i <= ETH_SUB_DLAST) ||
        sub_i == ETH_SUB_TSTAMP)) : 1'b0;

  // registered answer one cycle after the request
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_ack_o  <= 1'b0;
      rd_err_o  <= 1'b0;
      rd_data_o <= RST_BYTE;
    end else begin
      rd_ack_o  <= rd_req_i;
      rd_err_o  <= rd_req_i & ~hit;
      if (rd_req_i) rd_data_o <= hit ? record_i[pos*8 +: 8] : RST_BYTE;
    end
  end
endmodule : dru_reader

// ### test/dru_top_checker.sv
`timescale 1ns/10ps
// timing relations seen at the top ports
module dru_chk
  import dru_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic        diag_irq_en_i,
  input wire logic        rd_req_i,
  input dru_acc_t         acc_mode_i,
  input wire logic [15:0] sel_i,
  input wire logic [4:0]  ofs_i,
  input wire logic        irq_coming_o,
  input wire logic        irq_going_o,
  input wire logic        irq_active_o,
  input wire logic        record_valid_o,
  input wire logic        module_fault_lamp_o,
  input wire logic [31:0] tick_o,
  input wire logic        rd_ack_o,
  input wire logic        rd_err_o,
  input wire logic [7:0]  rd_data_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // request decode
  wire rec_rd = rd_req_i && acc_mode_i == ACC_RECORD;
  wire obj_rd = rd_req_i && acc_mode_i == ACC_OBJECT;
  property p_en_gate; !diag_irq_en_i [*3] |-> !irq_coming_o; endproperty
  a_en_gate: assert property (p_en_gate) else $error("coming while disabled");
  property p_valid; irq_coming_o |-> ##[0:3] record_valid_o; endproperty
  a_valid: assert property (p_valid) else $error("record not valid");
  property p_going; irq_going_o |-> $past(irq_active_o); endproperty
  a_going: assert property (p_going) else $error("going without active");
  property p_lamp_on; irq_coming_o |-> ##[0:1] module_fault_lamp_o; endproperty
  a_lamp_on: assert property (p_lamp_on) else $error("lamp not lit");
  property p_lamp_off; irq_going_o |-> ##[0:1] !module_fault_lamp_o; endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp still lit");
  property p_ack; rd_req_i |=> rd_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_no_ack; !rd_req_i |=> !rd_ack_o && !rd_err_o; endproperty
  a_no_ack: assert property (p_no_ack) else $error("answer without request");
  property p_head_err; rec_rd && sel_i[7:0] == 8'h00 && ofs_i >= 5'd4 |=> rd_err_o; endproperty
  a_head_err: assert property (p_head_err) else $error("head record overrun");
  property p_obj_err; obj_rd && sel_i == 16'h2F00 && ofs_i >= 5'd4 |=> rd_err_o; endproperty
  a_obj_err: assert property (p_obj_err) else $error("head object overrun");
  property p_class;
    rec_rd && sel_i[7:0] == 8'h01 && ofs_i == 5'd1 |=> rd_data_o == 8'h15 && !rd_err_o;
  endproperty
  a_class: assert property (p_class) else $error("class byte wrong");
  property p_tick; $changed(tick_o) |-> tick_o == $past(tick_o) + 32'h1 ##1 $stable(tick_o) [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("ticker step wrong");
  c_coming: cover property (irq_coming_o);
  c_going: cover property (irq_going_o);
  c_err: cover property (rd_err_o);
endmodule : dru_chk
bind dru_top dru_chk dru_chk_i (.core_clk_i, .srst_i, .diag_irq_en_i, .rd_req_i, .acc_mode_i,
  .sel_i, .ofs_i, .irq_coming_o, .irq_going_o, .irq_active_o, .record_valid_o,
  .module_fault_lamp_o, .tick_o, .rd_ack_o, .rd_err_o, .rd_data_o);

// ### test/dru_host_model.sv
`timescale 1ns/10ps
// head station: one read at a time, answer taken one cycle after the request
module dru_host_model
  import dru_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rd_ack_i,
  input  wire logic        rd_err_i,
  input  wire logic [7:0]  rd_data_i,
  output logic             rd_req_o,
  output dru_acc_t         acc_mode_o,
  output logic      [15:0] sel_o,
  output logic      [7:0]  sub_o,
  output logic      [4:0]  ofs_o
);
  int n_lost = 0;
  initial begin
    {rd_req_o, sel_o, sub_o, ofs_o} = '0;
    acc_mode_o = ACC_RECORD;
  end
  // record/object/subindex read; selectors scrambled once released
  task automatic rd(input dru_acc_t m, input logic [15:0] s, input logic [7:0] b,
                    input logic [4:0] o, output logic [7:0] d, output logic e);
    @(negedge core_clk_i);
    {rd_req_o, acc_mode_o, sel_o, sub_o, ofs_o} = {1'b1, m, s, b, o};
    @(negedge core_clk_i);
    rd_req_o = 1'b0;
    {sel_o, sub_o, ofs_o} = ~{s, b, o};
    @(posedge core_clk_i);
    d = rd_data_i;
    e = rd_err_i;
    if (rd_ack_i !== 1'b1) n_lost++;
    @(negedge core_clk_i);
  endtask : rd
endmodule : dru_host_model

// ### test/dru_top_tb.sv
`timescale 1ns/10ps
module dru_top_tb;
  import dru_pkg::*;
  logic        clk, srst, en, exc, mfail, exterr, e;
  logic [5:0]  cz; // aux, buffer, comm, config, under, over
  logic        coming, going, active, valid, lamp, ack, err, req;
  logic [31:0] tick, st;
  logic [7:0]  rdata, sub, d;
  logic [15:0] sel;
  logic [4:0]  ofs;
  dru_acc_t    mode;
  int n_mismatch = 0, n_checks = 0, cyc = 0, rel = 0, n_coming = 0, seed = 15843, r0, n0, o;
  dru_top dru_top_i (.core_clk_i(clk), .srst_i(srst), .diag_irq_en_i(en), .aux_missing_i(cz[0]),
    .buf_overflow_i(cz[1]), .comm_error_i(cz[2]), .config_error_i(cz[3]), .range_under_i(cz[4]),
    .range_over_i(cz[5]), .exc_short_i(exc), .module_failure_i(mfail),
    .external_error_i(exterr), .rd_req_i(req), .acc_mode_i(mode), .sel_i(sel), .sub_i(sub),
    .ofs_i(ofs), .irq_coming_o(coming), .irq_going_o(going), .irq_active_o(active),
    .record_valid_o(valid), .module_fault_lamp_o(lamp), .tick_o(tick), .rd_ack_o(ack),
    .rd_err_o(err), .rd_data_o(rdata));
  dru_host_model dru_host_model_i (.core_clk_i(clk), .rd_ack_i(ack), .rd_err_i(err),
    .rd_data_i(rdata), .rd_req_o(req), .acc_mode_o(mode), .sel_o(sel), .sub_o(sub), .ofs_o(ofs));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cycle counts and hang guard
  always @(posedge clk) begin
    cyc++;
    rel = srst ? 0 : rel + 1;
    if (coming === 1'b1) n_coming++;
    if (cyc == 40000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    chk(($isunknown(got) || got < lo || got > hi) ? 32'hFFFF_FFFF : got, got);
  endtask : chk_rng
  // expected record byte from the faults the bench applies
  function automatic logic [7:0] exp_byte(input int k);
    logic ch;
    ch = cz[3] | exc | cz[4] | cz[5];
    case (k)
      0: return {cz[3], 2'b00, cz[0], ch, exterr, 1'b0, mfail};
      1: return 8'h15;
      3: return {3'b000, cz[2], cz[1], 3'b000};
      4: return 8'h71;
      5: return 8'h08;
      6: return 8'h01;
      7: return {7'h00, ch};
      8: return {cz[5], cz[4], 2'b00, exc, 2'b00, cz[3]};
      default: return 8'h00;
    endcase
  endfunction : exp_byte
  // access kind: 0/1 record full/head, 2/3 object full/head, 4 subindex
  function automatic int pick(input int k);
    int r;
    r = $unsigned($random(seed)) % 5;
    if (k >= 4 && (r == 1 || r == 3)) r = r - 1;
    if (k > 16 && r == 4) r = 2;
    return r;
  endfunction : pick
  task automatic rd(input int a, input int k);
    dru_host_model_i.rd(a == 4 ? ACC_ETHSUB : (a >= 2 ? ACC_OBJECT : ACC_RECORD),
      a == 4 ? 16'h5005 : a == 2 ? 16'h2F01 : a == 3 ? 16'h2F00 : 16'(a == 0),
      k < 16 ? 8'(k + 2) : 8'h13, 5'(k), d, e);
  endtask : rd
  task automatic wait_pulse(input bit gone);
    int k;
    k = 0;
    while ((gone ? going : coming) !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk(k < 20, 1);
  endtask : wait_pulse
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    {srst, en, cz, exc, mfail, exterr} = 11'h400;
    repeat (8) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    chk({valid, active, lamp}, 0);
    for (int k = 0; k < 20; k++) begin
      rd(0, k);
      chk(d, exp_byte(k));
    end
    $display("test defaults done");
    en = 1'b1;
    for (int c = 0; c < 6; c++) begin
      {exc, mfail, exterr} = 3'($random(seed));
      r0 = rel;
      cz = 6'h01 << c;
      wait_pulse(1'b0);
      repeat (3) @(negedge clk);
      chk(lamp, 1);
      chk(active, 1);
      chk(valid, 1);
      for (int k = 0; k < 20; k++) begin
        rd(pick(k), k);
        if (k < 16) chk(d, exp_byte(k));
        else st[(k - 16) * 8 +: 8] = d;
      end
      chk_rng(st, (r0 - 2) / 20, (r0 + 8) / 20);
      cz = 6'h00;
      wait_pulse(1'b1);
      repeat (2) @(negedge clk);
      chk(lamp, 0);
      chk(active, 0);
    end
    $display("test causes done");
    rd(4, 16);
    chk_rng({24'h00_0000, d}, (r0 - 2) / 20, (r0 + 8) / 20);
    for (int k = 0; k < 5; k++) begin
      if (k < 3) rd(k == 0 ? 1 : k == 1 ? 3 : 0, k < 2 ? 4 : 20);
      else dru_host_model_i.rd(k == 3 ? ACC_ETHSUB : ACC_RECORD, k == 3 ? 16'h5005 : 16'h0002,
        8'h12, 5'h00, d, e);
      chk({e, d}, 9'h100);
    end
    $display("test refusals done");
    en = 1'b0;
    n0 = n_coming;
    cz = 6'h08;
    repeat (12) @(negedge clk);
    chk(n_coming - n0, 0);
    chk(lamp, 0);
    rd(0, 0);
    chk(d, exp_byte(0));
    cz = 6'h00;
    $display("test disabled done");
    for (int i = 0; i < 40; i++) begin
      {en, cz, exc, mfail, exterr} = 10'($random(seed));
      repeat (5) @(negedge clk);
      for (int j = 0; j < 3; j++) begin
        o = $unsigned($random(seed)) % 16;
        rd(pick(o), o);
        chk({e, d}, {1'b0, exp_byte(o)});
      end
    end
    $display("test random done");
    chk(dru_host_model_i.n_lost, 0);
    chk_rng(tick, (rel - 2) / 20, (rel + 1) / 20);
    close_out();
  end
endmodule : dru_top_tb
